// ===== shared/timer8_regs.vh
`ifndef TIMER8_REGS_VH
`define TIMER8_REGS_VH

// Register indices (printed offsets are not all multiples of four)
`define PRESCALER_VALUE_IDX 8'hD2
`define COUNT_VALUE_IDX     8'hD3
`define CTRL_STATUS_IDX     8'hD4

// Control/status field positions
`define UNDERFLOW_FLAG_BIT  7
`define IRQ_ENABLE_BIT      6
`define PIN_DIRECTION_BIT   5
`define PIN_DATA_BIT        4
`define PRESCALER_RUN_BIT   3
`define DIVISION_SEL_MSB    2
`define DIVISION_SEL_LSB    0

// Reset and reload values
`define PRESCALER_RESET     7'h7F
`define COUNT_RESET         8'hFF
`define CTRL_RESET          8'h00

// Internal clock divider ratio
`define INT_CLOCK_DIVIDE    4'hC

`endif

// ===== core/prescaled_downcounter.v
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "timer8_regs.vh"

// Contract
// R1: Prescaler clocked by internal clock divided by 12 or by timer pin, per mode.
// R2: Prescaler reaching zero reloads with 7Fh.
// R3: Counter decrements once per rising edge of the selected prescaler tap.
// R4: Counter at zero reloads 0FFh on the next count.
// R5: Division select picks one of eight taps, dividing by 2 to the field.
// R6: Run bit clear freezes counter, holds prescaler at 7Fh; set lets both run.
// R7: Reset sets counter to 0FFh and prescaler to 7Fh.
// R8: With run bit set, software may write prescaler values 0 to 7Fh.
// R9: Counter readable and writable anytime; write loads it independent of prescaler.
// R10: Decrement to zero sets underflow flag; with irq enable, interrupt request.
// R11: Writing 00h to counter or one to control bit 7 also sets flag.
// R12: Software clears underflow flag during service; hardware never clears it.
// R13: Counter write coinciding with decrement to 00h wins; no flag set.
// R14: Mode from direction and data bits: 00 event, 01 gated, 1x output.
// R15: Gated mode counts divided internal clock only while timer pin is high.
// R16: Event mode decrements prescaler on each rising edge at timer pin.
// R17: Output mode clocks prescaler from internal clock divided by 12.
// R18: Flag rising latches data bit; direction set drives latched value on pin.
// R19: Direction bit set makes timer pin a push-pull output immediately; here the pin enable follows the bit one clock later.
// R20: Wait state leaves timer running; its interrupt wakes the processor.
// R21: Stop state freezes timer except in event counter mode.
// R22: Software configures shared pin as input with pull-up in input modes.
// R23: Control/status at 0D4h, reset 00h, fields flag,ie,dir,data,run,select.
// R24: Counter value register at 0D3h, read/write, reset FFh.
// R25: Prescaler register at 0D2h, reset 7Fh, bit 7 reads zero.
// R26: Interrupt request is a level while flag and irq enable both set.
module prescaled_downcounter #(
  parameter PRESC_W = 7,
  parameter COUNT_W = 8
) (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Timer pin
  input  wire        timer_pin_in,
  output reg         timer_pin_out,
  output reg         timer_pin_oe,
  // Power state
  input  wire        stop_mode,
  // Interrupt request
  output reg         timer_irq
);

  localparam MODE_EVENT  = 2'b00;
  localparam MODE_GATED  = 2'b01;
  localparam MODE_OUTPUT = 2'b10;

  reg [PRESC_W-1:0] prescaler_reg;
  reg [PRESC_W-1:0] prescaler_next;
  reg [COUNT_W-1:0] count_reg;
  reg [COUNT_W-1:0] count_next;
  reg [7:0]         ctrl_reg;
  reg [7:0]         ctrl_next;
  reg [3:0]         div12_reg;
  reg               pin_meta_reg;
  reg               pin_sync_reg;
  reg               pin_prev_reg;
  reg               data_latch_reg;
  reg               tap_prev_reg;
  reg               flag_prev_reg;

  wire       run       = ctrl_reg[`PRESCALER_RUN_BIT];
  wire       dir       = ctrl_reg[`PIN_DIRECTION_BIT];
  wire [2:0] div_sel   = ctrl_reg[`DIVISION_SEL_MSB:`DIVISION_SEL_LSB];
  wire [1:0] mode      = dir ? MODE_OUTPUT :
                         (ctrl_reg[`PIN_DATA_BIT] ? MODE_GATED : MODE_EVENT); // R14
  wire       div12_hit = (div12_reg == `INT_CLOCK_DIVIDE - 4'h1);
  wire       pin_rise  = pin_sync_reg & ~pin_prev_reg;

  // APB decode; word index is byte address over four
  wire       access    = psel & penable;
  wire       wr_ok     = access & pwrite & pstrb[0];
  wire [9:0] word_idx  = paddr[11:2];
  wire       hit_presc = (word_idx == {2'b00, `PRESCALER_VALUE_IDX});
  wire       hit_count = (word_idx == {2'b00, `COUNT_VALUE_IDX});
  wire       hit_ctrl  = (word_idx == {2'b00, `CTRL_STATUS_IDX});
  wire       mapped    = hit_presc | hit_count | hit_ctrl;

  // Prescaler input tick selection
  reg presc_tick;
  always @* begin
    case (mode)
      MODE_EVENT:  presc_tick = pin_rise;                 // R16 R1 R21
      MODE_GATED:  presc_tick = div12_hit & pin_sync_reg; // R15
      MODE_OUTPUT: presc_tick = div12_hit;                // R17
      default:     presc_tick = 1'b0;
    endcase
    // Stop freezes everything but pin-clocked counting; wait has no effect
    if (stop_mode && mode != MODE_EVENT)
      presc_tick = 1'b0;                                  // R21 R20
  end

  // Tap i toggles at prescaler clock over 2^i; tap 0 is tied low, select 0 takes the raw tick
  wire [PRESC_W-1:0] down_cnt = ~prescaler_reg;
  wire [PRESC_W:0]   taps;
  genvar             ti;

  assign taps[0] = 1'b0;
  generate
    for (ti = 0; ti < PRESC_W; ti = ti + 1) begin : g_tap
      assign taps[ti+1] = down_cnt[ti];
    end
  endgenerate

  wire               tap_val  = taps[div_sel];            // R5
  wire               count_tick = run & presc_tick &
                                  ((div_sel == 3'h0) | (~tap_prev_reg & tap_val)); // R3

  reg write_zero_flag;
  reg hw_underflow;
  always @* begin
    prescaler_next  = prescaler_reg;
    count_next      = count_reg;
    ctrl_next       = ctrl_reg;
    write_zero_flag = 1'b0;
    hw_underflow    = 1'b0;
    if (!run) begin
      prescaler_next = `PRESCALER_RESET;                  // R6
    end else if (presc_tick) begin
      if (prescaler_reg == {PRESC_W{1'b0}})
        prescaler_next = `PRESCALER_RESET;                // R2
      else
        prescaler_next = prescaler_reg - 1'b1;
    end
    if (count_tick) begin
      if (count_reg == {COUNT_W{1'b0}})
        count_next = `COUNT_RESET;                        // R4
      else
        count_next = count_reg - 1'b1;
      hw_underflow = (count_reg == {{(COUNT_W-1){1'b0}}, 1'b1}); // R10
    end
    if (wr_ok && hit_presc && run)
      prescaler_next = pwdata[PRESC_W-1:0];               // R8
    if (wr_ok && hit_count) begin
      count_next      = pwdata[COUNT_W-1:0];              // R9
      hw_underflow    = 1'b0;                             // R13
      write_zero_flag = (pwdata[COUNT_W-1:0] == {COUNT_W{1'b0}}); // R11
    end
    if (wr_ok && hit_ctrl)
      ctrl_next = pwdata[7:0];                            // R12 R11
    // Hardware set beats a coincident software clear
    if (hw_underflow || write_zero_flag)
      ctrl_next[`UNDERFLOW_FLAG_BIT] = 1'b1;              // R10 R11
  end

  // Divider stalls in stop so the internal clock source is frozen
  reg [3:0]  div12_next;
  always @* begin
    div12_next = div12_reg;
    if (!stop_mode)
      div12_next = div12_hit ? 4'h0 : div12_reg + 4'h1;   // R1
  end

  // Tap history moves only with the prescaler, so one tap edge is one count
  reg        tap_prev_next;
  always @* begin
    tap_prev_next = tap_prev_reg;
    if (presc_tick)
      tap_prev_next = tap_val;
  end

  // Flag history for the rising-edge latch
  wire       flag_now  = ctrl_reg[`UNDERFLOW_FLAG_BIT];
  wire       flag_rise = flag_now & ~flag_prev_reg;

  // Output latch follows the flag's rising edge only
  reg        data_latch_next;
  always @* begin
    data_latch_next = data_latch_reg;
    if (flag_rise)
      data_latch_next = ctrl_reg[`PIN_DATA_BIT];          // R18
  end

  // Pin drive; enable lags the direction bit by one clock
  reg        pin_out_next;
  reg        pin_oe_next;
  always @* begin
    pin_out_next = data_latch_reg;                        // R18
    pin_oe_next  = dir;                                   // R19
  end

  // Level request also serves as the wake event
  reg        irq_next;
  always @* begin
    irq_next = flag_now & ctrl_reg[`IRQ_ENABLE_BIT];      // R26 R20
  end

  // Zero-wait slave: pready high in the first cycle of the access phase
  reg        pready_next;
  reg        pslverr_next;
  always @* begin
    pready_next  = psel & ~penable;
    pslverr_next = psel & ~penable & ~mapped;             // R23
  end

  // Read data captured at setup and held until the next read setup
  reg [31:0] rd_data_next;
  always @* begin
    rd_data_next = prdata;
    if (psel && !penable && !pwrite) begin
      case (word_idx)
        {2'b00, `PRESCALER_VALUE_IDX}: rd_data_next = {25'h0000000, prescaler_reg}; // R25
        {2'b00, `COUNT_VALUE_IDX}:     rd_data_next = {24'h000000, count_reg};      // R24
        {2'b00, `CTRL_STATUS_IDX}:     rd_data_next = {24'h000000, ctrl_reg};       // R23
        default:                       rd_data_next = 32'h0000_0000;
      endcase
    end
  end

  // Prescaler
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescaler_reg <= `PRESCALER_RESET;                  // R7 R25
    end else begin
      prescaler_reg <= prescaler_next;
    end
  end

  // Counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= `COUNT_RESET;                          // R7 R24
    end else begin
      count_reg <= count_next;
    end
  end

  // Control and status
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `CTRL_RESET;                            // R23
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Internal divider
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div12_reg <= 4'h0;
    end else begin
      div12_reg <= div12_next;
    end
  end

  // First synchroniser stage; nothing but the second stage reads it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_reg <= 1'b0;
    end else begin
      pin_meta_reg <= timer_pin_in;
    end
  end

  // Second synchroniser stage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_reg <= 1'b0;
    end else begin
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Pin history for edge detection
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // Tap history
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tap_prev_reg <= 1'b0;
    end else begin
      tap_prev_reg <= tap_prev_next;
    end
  end

  // Flag history
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_prev_reg <= 1'b0;
    end else begin
      flag_prev_reg <= flag_now;
    end
  end

  // Output data latch
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_latch_reg <= 1'b0;
    end else begin
      data_latch_reg <= data_latch_next;
    end
  end

  // Driven pin level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_pin_out <= 1'b0;
    end else begin
      timer_pin_out <= pin_out_next;
    end
  end

  // Pin output enable
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_pin_oe <= 1'b0;
    end else begin
      timer_pin_oe <= pin_oe_next;
    end
  end

  // Interrupt request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= irq_next;
    end
  end

  // Read data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= rd_data_next;
    end
  end

  // Ready
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= pready_next;
    end
  end

  // Slave error
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= pslverr_next;
    end
  end

endmodule

`default_nettype wire

// ===== tb/prescaled_downcounter_props.sv
`timescale 1ns/1ns
`default_nettype none
module prescaled_downcounter_props (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pin and interrupt
  input wire logic        timer_pin_oe,
  input wire logic        timer_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire mapped = paddr == 12'h348 || paddr == 12'h34C || paddr == 12'h350;
  wire wc = psel && penable && pwrite && pready && pstrb[0] && paddr == 12'h350;
  sequence s_wc; wc; endsequence
  // Two quiet edges, since the pin enable lags the control bit by one
  sequence s_quiet; !wc [*2]; endsequence
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_err; pready |-> pslverr == !mapped; endproperty
  a_err: assert property (p_err) else $error("wrong slave error");
  property p_upper; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_psc7; pready && !pwrite && paddr == 12'h348 |-> !prdata[7]; endproperty
  a_psc7: assert property (p_psc7) else $error("prescaler bit 7 set");
  property p_oe; s_wc |=> ##1 timer_pin_oe == $past(pwdata[5], 2); endproperty
  a_oe: assert property (p_oe) else $error("pin enable not direction");
  property p_oe_hold; s_quiet |=> $stable(timer_pin_oe); endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("pin enable moved");
  property p_irq_set; s_wc ##0 pwdata[7:6] == 2'b11 |=> ##1 timer_irq; endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq missing");
  property p_irq_off; s_wc ##0 !pwdata[6] |=> ##1 !timer_irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
endmodule
bind prescaled_downcounter prescaled_downcounter_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_pin_oe(timer_pin_oe), .timer_irq(timer_irq));
`default_nettype wire

// ===== tb/timer_pin_source.sv
`timescale 1ns/1ns
`default_nettype none
module timer_pin_source (
  // Bench side
  input wire logic ext_en,
  input wire logic ext_lvl,
  // Device side
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic     pin
);
  // Pull-up wins when nobody drives the line
  assign pin = pin_oe ? pin_out : (ext_en ? ext_lvl : 1'b1);
endmodule
`default_nettype wire

// ===== tb/prescaled_downcounter_tb.sv
`timescale 1ns/1ns
`default_nettype none
module prescaled_downcounter_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, stop_mode = 0;
  logic        ext_en = 1, ext_lvl = 0, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, r, r1;
  wire  [31:0] prdata;
  wire         pready, pslverr, pin, timer_pin_out, timer_pin_oe, timer_irq;
  int          n_errors = 0, check_count = 0;
  prescaled_downcounter u_prescaled_downcounter (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_pin_in(pin),
    .timer_pin_out(timer_pin_out), .timer_pin_oe(timer_pin_oe), .stop_mode(stop_mode),
    .timer_irq(timer_irq));
  timer_pin_source u_timer_pin_source (.ext_en(ext_en), .ext_lvl(ext_lvl),
    .pin_out(timer_pin_out), .pin_oe(timer_pin_oe), .pin(pin));
  initial forever #2 pclk = ~pclk;
  task results();
    if (n_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, 24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) n_errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task pulse();
    @(posedge pclk) ext_lvl <= 1'b1;
    repeat (4) @(posedge pclk);
    ext_lvl <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  task t_reset();
    apb(0, 12'h348, 8'h00); chk(r, 32'h7F);
    apb(0, 12'h34C, 8'h00); chk(r, 32'hFF);
    apb(0, 12'h350, 8'h00); chk(r, 32'h00);
    apb(0, 12'h354, 8'h00); chk({r[30:0], e}, 32'h1);
    apb(1, 12'h348, 8'h10); apb(0, 12'h348, 8'h00); chk(r, 32'h7F);
  endtask
  task t_output();
    int k;
    apb(1, 12'h34C, 8'h03);
    apb(1, 12'h350, 8'h78);
    for (k = 0; k < 200 && timer_irq !== 1'b1; k++) @(posedge pclk);
    chk(timer_irq, 32'h1);
    chk(timer_pin_oe, 32'h1);
    // Reload lands one prescaler tick (12 clocks) after zero
    repeat (12) @(posedge pclk);
    apb(0, 12'h34C, 8'h00); chk(r, 32'hFF);
    apb(0, 12'h350, 8'h00); chk(r, 32'hF8);
    chk(timer_pin_out, 32'h1);
    apb(1, 12'h350, 8'h68); repeat (2) @(posedge pclk); chk(timer_irq, 32'h0);
    chk(timer_pin_out, 32'h1);
    apb(1, 12'h34C, 8'h00); apb(0, 12'h350, 8'h00); chk(r, 32'hE8);
    chk(timer_pin_out, 32'h0);
  endtask
  task t_event();
    apb(1, 12'h350, 8'h08);
    apb(1, 12'h348, 8'h05); apb(0, 12'h348, 8'h00); chk(r, 32'h05);
    stop_mode <= 1'b1;
    repeat (3) pulse();
    apb(0, 12'h348, 8'h00); chk(r, 32'h02);
    stop_mode <= 1'b0;
    apb(1, 12'h350, 8'h00); apb(0, 12'h348, 8'h00); chk(r, 32'h7F);
  endtask
  task t_gated();
    apb(1, 12'h350, 8'h18);
    repeat (40) @(posedge pclk);
    apb(0, 12'h348, 8'h00); chk(r, 32'h7F);
    ext_lvl <= 1'b1;
    repeat (40) @(posedge pclk);
    apb(0, 12'h348, 8'h00); chk(r < 32'h7F, 32'h1);
    stop_mode <= 1'b1;
    apb(0, 12'h348, 8'h00); r1 = r;
    repeat (30) @(posedge pclk);
    apb(0, 12'h348, 8'h00); chk(r, r1);
  endtask
  initial begin
    #40000;
    n_errors++;
    results();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_output();
    t_event();
    t_gated();
    results();
  end
endmodule
`default_nettype wire
